// ===== logic/ftr_timer.sv
// Timer front end: counter, buffered reload, output override, register bus.
// Assumes an Avalon-MM master on clk_sys_i and synchronous inputs other than ext_clk_i.
//
// Implementation choice: register access over Avalon-MM.
`timescale 1ns/100ps
`include "ftr_cfg.svh"

// Contract
// R1: Override enable on channel 0 or 1 forces that output to override level.
// R2: Override level 0 drives output low, 1 drives it high.
// R3: On leaving period end, copy period, start, compare buffers to active.
// R4: A selected channel match also triggers the buffered load.
// R5: Load permit bit 9 gates every buffered load.
// R6: Match select bits 7..0 include each channel's match as a trigger.
// R7: Load control bits 31..10 and 8 read zero.
// R8: Load control decodes at byte offset 0x98.
// R9: Everything runs on the system clock only.
// R10: Two-bit clock select picks system, fixed, external, or none.
// R11: Clock select resets to 00.
// R12: Writing 00 stops counting but keeps counter and registers.
// R13: Fixed clock runs at most half the system clock.
// R14: External clock passes a system-clock synchroniser.
// R15: External clock runs at most a quarter of system clock.
// R16: Selected clock feeds a 7-bit prescaler with 3-bit select.
// R17: Main 16-bit counter advances only on prescaler ticks.
// R18: At period end counter reloads with start value.
// R19: Prescale select k divides by two to the power k.
module ftr_timer
	import ftr_pkg::*;
(
	input  wire logic        clk_sys_i,
	input  wire logic        srst_i,
	input  wire logic [7:0]  avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [31:0] avs_writedata_i,
	input  wire logic [3:0]  avs_byteenable_i,
	output logic [31:0]      avs_readdata_o,
	output logic             avs_waitrequest_o,
	input  wire logic        fixed_clk_i,
	input  wire logic        ext_clk_i,
	input  wire logic [1:0]  ch_norm_i,
	output logic [1:0]       ch_out_o,
	output logic [15:0]      count_o,
	output logic             load_pulse_o
);
	localparam int NCH = `FTR_NUM_CH;

	logic [1:0]  counter_clock_select_r, counter_clock_select_nxt;
	logic [2:0]  ps_r, ps_nxt;
	logic [15:0] cnt_r, cnt_nxt;
	logic [15:0] mod_r, mod_nxt, mod_buf_r, mod_buf_nxt;
	logic [15:0] cin_r, cin_nxt, cin_buf_r, cin_buf_nxt;
	logic [15:0] cv_r [NCH];
	logic [15:0] cv_nxt [NCH];
	logic [15:0] cv_buf_r [NCH];
	logic [15:0] cv_buf_nxt [NCH];
	logic [8:0]  load_r, load_nxt;
	logic [3:0]  swo_r, swo_nxt;
	logic [1:0]  out_r, out_nxt;
	logic [31:0] rd_r, rd_nxt;
	logic        lp_r, lp_nxt;
	ftr_bus_st_t st_r, st_nxt;
	logic        tick, at_end, match, do_load;
	logic        wr_acc;
	logic [31:0] wmask;

	function automatic logic [31:0] byte_mask(input logic [3:0] be);
		byte_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
	endfunction

	// Low 16 bits only; upper lanes have no storage behind them
	function automatic logic [15:0] merge(input logic [15:0] old,
		input logic [31:0] nw, input logic [31:0] m);
		merge = (old & ~m[15:0]) | (nw[15:0] & m[15:0]);
	endfunction

	ftr_prescale u_pre (
		.clk_sys_i   (clk_sys_i),
		.srst_i      (srst_i),
		.clk_sel_i   (counter_clock_select_r),
		.ps_sel_i    (ps_r),
		.fixed_clk_i (fixed_clk_i),
		.ext_clk_i   (ext_clk_i),
		.tick_o      (tick)
	);

	// ----------------------------------------------------------------
	// Bus handshake
	// ----------------------------------------------------------------
	// One wait cycle per access keeps read data registered
	assign avs_waitrequest_o = (avs_read_i | avs_write_i) &
		(st_r == FTR_BUS_IDLE);
	// Write lands at the edge where waitrequest is seen low
	assign wr_acc = avs_write_i & (st_r == FTR_BUS_ANSWER);
	assign wmask  = byte_mask(avs_byteenable_i);

	always_comb begin
		st_nxt = FTR_BUS_IDLE;
		if ((avs_read_i | avs_write_i) && st_r == FTR_BUS_IDLE)
			st_nxt = FTR_BUS_ANSWER;
	end

	// ----------------------------------------------------------------
	// Counter and reload
	// ----------------------------------------------------------------
	always_comb begin
		match = 1'b0;
		for (int i = 0; i < NCH; i++)
			if (load_r[i] && cnt_r == cv_r[i]) // [R4] [R6]
				match = 1'b1;
	end

	assign at_end  = tick && cnt_r == mod_r;
	// Load happens at the tick leaving a match or period end
	assign do_load = load_r[`FTR_LOAD_PERMIT - 1] && // [R5]
		(at_end || (tick && match)); // [R3] [R4]

	always_comb begin
		cnt_nxt     = cnt_r;
		mod_nxt     = mod_r;
		cin_nxt     = cin_r;
		mod_buf_nxt = mod_buf_r;
		cin_buf_nxt = cin_buf_r;
		counter_clock_select_nxt    = counter_clock_select_r;
		ps_nxt      = ps_r;
		load_nxt    = load_r;
		swo_nxt     = swo_r;
		for (int i = 0; i < NCH; i++) begin
			cv_nxt[i]     = cv_r[i];
			cv_buf_nxt[i] = cv_buf_r[i];
		end
		if (tick)
			cnt_nxt = at_end ? cin_r : cnt_r + 16'h0001; // [R17] [R18]
		if (do_load) begin
			mod_nxt = mod_buf_r; // [R3]
			cin_nxt = cin_buf_r;
			for (int i = 0; i < NCH; i++)
				cv_nxt[i] = cv_buf_r[i];
		end
		if (wr_acc) begin
			unique case (avs_address_i)
				`FTR_OFF_SC: begin
					// Stopping leaves counter untouched
					if (avs_byteenable_i[0]) begin
						counter_clock_select_nxt = avs_writedata_i[4:3]; // [R12]
						ps_nxt   = avs_writedata_i[2:0];
					end
				end
				`FTR_OFF_CNT: cnt_nxt = cin_r;
				`FTR_OFF_MOD:
					mod_buf_nxt = merge(mod_buf_r,
						avs_writedata_i, wmask);
				`FTR_OFF_COUNTER_START_VALUE:
					cin_buf_nxt = merge(cin_buf_r,
						avs_writedata_i, wmask);
				`FTR_OFF_SWO:
					swo_nxt = {avs_writedata_i[9:8], avs_writedata_i[1:0]};
				`FTR_OFF_LOAD: begin // [R8]
					if (avs_byteenable_i[0])
						load_nxt[7:0] = avs_writedata_i[7:0]; // [R6]
					if (avs_byteenable_i[1])
						load_nxt[8] = avs_writedata_i[9]; // [R5]
				end
				default: begin
					for (int i = 0; i < NCH; i++)
						if (avs_address_i == `FTR_OFF_CV0 +
							8'(i) * `FTR_CV_STRIDE)
							cv_buf_nxt[i] = merge(cv_buf_r[i],
								avs_writedata_i, wmask);
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Read mux and outputs
	// ----------------------------------------------------------------
	always_comb begin
		rd_nxt = rd_r;
		if (avs_read_i && st_r == FTR_BUS_IDLE) begin
			rd_nxt = 32'h0000_0000;
			unique case (avs_address_i)
				`FTR_OFF_SC:    rd_nxt = {27'h0, counter_clock_select_r, ps_r};
				`FTR_OFF_CNT:   rd_nxt = {16'h0000, cnt_r};
				`FTR_OFF_MOD:   rd_nxt = {16'h0000, mod_r};
				`FTR_OFF_COUNTER_START_VALUE: rd_nxt = {16'h0000, cin_r};
				`FTR_OFF_SWO:
					rd_nxt = {22'h0, swo_r[3:2], 6'h00, swo_r[1:0]};
				// Bits 31..10 and 8 read zero
				`FTR_OFF_LOAD:
					rd_nxt = {22'h0, load_r[8], 1'b0, load_r[7:0]}; // [R7]
				default: begin
					for (int i = 0; i < NCH; i++)
						if (avs_address_i == `FTR_OFF_CV0 +
							8'(i) * `FTR_CV_STRIDE)
							rd_nxt = {16'h0000, cv_r[i]};
				end
			endcase
		end
	end

	always_comb begin
		for (int c = 0; c < 2; c++)
			out_nxt[c] = swo_r[c] ? swo_r[c + 2] : ch_norm_i[c]; // [R1] [R2]
	end
	assign lp_nxt = do_load;

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			counter_clock_select_r    <= `FTR_COUNTER_CLOCK_SELECT_RST; // [R11]
			ps_r      <= `FTR_PS_RST;
			cnt_r     <= 16'h0000;
			mod_r     <= 16'h0000;
			cin_r     <= 16'h0000;
			mod_buf_r <= 16'h0000;
			cin_buf_r <= 16'h0000;
			load_r    <= `FTR_LOAD_RST;
			swo_r     <= `FTR_SWO_RST;
			out_r     <= 2'h0;
			rd_r      <= 32'h0000_0000;
			lp_r      <= 1'b0;
			st_r      <= FTR_BUS_IDLE;
			for (int i = 0; i < NCH; i++) begin
				cv_r[i]     <= 16'h0000;
				cv_buf_r[i] <= 16'h0000;
			end
		end else begin
			counter_clock_select_r    <= counter_clock_select_nxt;
			ps_r      <= ps_nxt;
			cnt_r     <= cnt_nxt;
			mod_r     <= mod_nxt;
			cin_r     <= cin_nxt;
			mod_buf_r <= mod_buf_nxt;
			cin_buf_r <= cin_buf_nxt;
			load_r    <= load_nxt;
			swo_r     <= swo_nxt;
			out_r     <= out_nxt;
			rd_r      <= rd_nxt;
			lp_r      <= lp_nxt;
			st_r      <= st_nxt;
			for (int i = 0; i < NCH; i++) begin
				cv_r[i]     <= cv_nxt[i];
				cv_buf_r[i] <= cv_buf_nxt[i];
			end
		end
	end

	assign avs_readdata_o = rd_r;
	assign ch_out_o       = out_r;
	assign count_o        = cnt_r;
	assign load_pulse_o   = lp_r;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (srst_i);

	sequence load_point_s;
		tick && load_r[8] && (cnt_r == mod_r);
	endsequence

	reload_on_end_a: assert property ( // [R18]
		tick && cnt_r == mod_r |=> cnt_r == $past(cin_r))
		else $error("Counter did not reload start value");
	period_copy_a: assert property ( // [R3]
		load_point_s |=> mod_r == $past(mod_buf_r) && load_pulse_o)
		else $error("Period buffer not copied at period end");
	permit_gate_a: assert property ( // [R5]
		!load_r[8] |=> $stable(mod_r) && $stable(cin_r))
		else $error("Buffered load without permit");
	match_load_a: assert property ( // [R4]
		tick && load_r[8] && match |=> cin_r == $past(cin_buf_r))
		else $error("Match did not trigger buffered load");
	stopped_hold_a: assert property ( // [R12]
		counter_clock_select_r == 2'h0 && !wr_acc |=> $stable(cnt_r))
		else $error("Counter moved with clock disabled");
	no_tick_a: assert property ( // [R17]
		!tick && !wr_acc |=> $stable(cnt_r))
		else $error("Counter moved without prescaler tick");
	override_out_a: assert property ( // [R1]
		swo_r[0] |=> ch_out_o[0] == $past(swo_r[2]))
		else $error("Channel 0 override level not driven");
	reserved_zero_a: assert property ( // [R7]
		avs_read_i && st_r == FTR_BUS_IDLE &&
		avs_address_i == `FTR_OFF_LOAD |=>
		avs_readdata_o[31:10] == 22'h0 && !avs_readdata_o[8])
		else $error("Reserved load control bits read nonzero");
	reset_sel_a: assert property ( // [R11]
		$fell(srst_i) |-> counter_clock_select_r == 2'h0)
		else $error("Clock select not zero after reset");
endmodule

// ===== logic/ftr_cfg.svh
// Register offsets, field positions and reset values for the timer front end.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef FTR_CFG_SVH
`define FTR_CFG_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define FTR_OFF_SC       8'h00
`define FTR_OFF_CNT      8'h04
`define FTR_OFF_MOD      8'h08
`define FTR_OFF_COUNTER_START_VALUE    8'h4C
`define FTR_OFF_CV0      8'h10
`define FTR_OFF_SWO      8'h94
`define FTR_OFF_LOAD     8'h98
`define FTR_CV_STRIDE    8'h08

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define FTR_SC_COUNTER_CLOCK_SELECT_LSB  3
`define FTR_SC_PS_LSB    0
`define FTR_LOAD_PERMIT  9
`define FTR_OVR_LVL_LSB  8

// ----------------------------------------------------------------
// Reset values and channel count
// ----------------------------------------------------------------
`define FTR_COUNTER_CLOCK_SELECT_RST     2'h0
`define FTR_PS_RST       3'h0
`define FTR_LOAD_RST     9'h000
`define FTR_SWO_RST      4'h0
`define FTR_NUM_CH       8

`endif

// ===== logic/ftr_pkg.sv
// Types for the timer clock, prescale and buffered reload front end.
// Assumes ftr_cfg.svh is on the include path.
`include "ftr_cfg.svh"

package ftr_pkg;
	typedef enum logic [1:0] {
		FTR_CLK_NONE,
		FTR_CLK_SYS,
		FTR_CLK_FIXED,
		FTR_CLK_EXT
	} ftr_clk_sel_t;

	typedef enum logic [1:0] {
		FTR_BUS_IDLE,
		FTR_BUS_ANSWER
	} ftr_bus_st_t;
endpackage

// ===== logic/ftr_prescale.sv
// Counter clock source selection, external clock synchroniser, prescaler.
// Assumes all inputs synchronous to clk_sys_i except ext_clk_i.
`timescale 1ns/100ps
`include "ftr_cfg.svh"

module ftr_prescale
	import ftr_pkg::*;
(
	input  wire logic       clk_sys_i,
	input  wire logic       srst_i,
	input  wire logic [1:0] clk_sel_i,
	input  wire logic [2:0] ps_sel_i,
	input  wire logic       fixed_clk_i,
	input  wire logic       ext_clk_i,
	output logic            tick_o
);
	logic       ext_s1_r, ext_s2_r, ext_s3_r;
	logic       fix_d_r;
	logic [6:0] pre_r, pre_nxt;
	logic       src_edge;
	logic       wrap;

	// ----------------------------------------------------------------
	// Synchroniser and edge detect
	// ----------------------------------------------------------------
	// First stage feeds only the second stage
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			ext_s1_r <= 1'b0;
			ext_s2_r <= 1'b0;
			ext_s3_r <= 1'b0;
			fix_d_r  <= 1'b0;
		end else begin
			ext_s1_r <= ext_clk_i; // [R14]
			ext_s2_r <= ext_s1_r;
			ext_s3_r <= ext_s2_r;
			fix_d_r  <= fixed_clk_i;
		end
	end

	// Other sources are qualifiers, not clocks
	always_comb begin
		unique case (ftr_clk_sel_t'(clk_sel_i)) // [R9] [R10]
			FTR_CLK_NONE:  src_edge = 1'b0;
			FTR_CLK_SYS:   src_edge = 1'b1;
			FTR_CLK_FIXED: src_edge = fixed_clk_i & ~fix_d_r;
			FTR_CLK_EXT:   src_edge = ext_s2_r & ~ext_s3_r;
		endcase
	end

	// ----------------------------------------------------------------
	// Prescaler
	// ----------------------------------------------------------------
	// Divide by 2**k: wrap when the low k bits are all ones
	assign wrap = &(pre_r | ~(7'h7F >> (3'h7 - ps_sel_i))) | // [R19]
		(ps_sel_i == 3'h0);

	always_comb begin
		pre_nxt = pre_r;
		if (src_edge)
			pre_nxt = wrap ? 7'h00 : pre_r + 7'h01; // [R16]
	end

	always_ff @(posedge clk_sys_i) begin
		if (srst_i)
			pre_r <= 7'h00;
		else
			pre_r <= pre_nxt;
	end

	assign tick_o = src_edge & wrap; // [R17]
endmodule

// ===== dv/ftr_timer_tb.sv
// Self-checking bench for the timer clock, prescale and reload front end.
// Assumes ftr_cfg.svh on the include path; assertions live in the design.
`timescale 1ns/100ps
`include "ftr_cfg.svh"

module ftr_timer_tb;
	import ftr_pkg::*;

	logic        clk_sys_i;
	logic        srst_i;
	logic [7:0]  avs_address_i;
	logic        avs_read_i;
	logic        avs_write_i;
	logic [31:0] avs_writedata_i;
	logic [3:0]  avs_byteenable_i;
	logic [31:0] avs_readdata_o;
	logic        avs_waitrequest_o;
	logic        fixed_clk_i;
	logic        ext_clk_i;
	logic [1:0]  ch_norm_i;
	logic [1:0]  ch_out_o;
	logic [15:0] count_o;
	logic        load_pulse_o;
	logic [1:0]  fdiv;
	int          mismatches;
	int          num_checks;
	int          pulses = 0;
	int          base;
	logic [15:0] held;

	ftr_timer i_dut (
		.clk_sys_i         (clk_sys_i),
		.srst_i            (srst_i),
		.avs_address_i     (avs_address_i),
		.avs_read_i        (avs_read_i),
		.avs_write_i       (avs_write_i),
		.avs_writedata_i   (avs_writedata_i),
		.avs_byteenable_i  (avs_byteenable_i),
		.avs_readdata_o    (avs_readdata_o),
		.avs_waitrequest_o (avs_waitrequest_o),
		.fixed_clk_i       (fixed_clk_i),
		.ext_clk_i         (ext_clk_i),
		.ch_norm_i         (ch_norm_i),
		.ch_out_o          (ch_out_o),
		.count_o           (count_o),
		.load_pulse_o      (load_pulse_o)
	);

	// ------------------------------------------------------------
	// Clocks and sources
	// ------------------------------------------------------------
	initial begin
		clk_sys_i = 1'b0;
		forever #4 clk_sys_i = ~clk_sys_i;
	end

	// Unrelated phase; rising edge every 10 cycles, under a quarter
	initial begin
		ext_clk_i = 1'b0;
		#3;
		forever #40 ext_clk_i = ~ext_clk_i;
	end

	// Fixed source at a quarter of the system rate, inside its limit
	always @(posedge clk_sys_i) begin
		fdiv <= srst_i ? 2'h0 : fdiv + 2'h1;
		fixed_clk_i <= fdiv[1];
	end

	always @(posedge clk_sys_i) begin
		if (load_pulse_o === 1'b1) pulses++;
	end

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int i;
		logic ok;
		@(posedge clk_sys_i);
		avs_address_i <= a;
		avs_write_i <= wr;
		avs_read_i <= !wr;
		avs_writedata_i <= d;
		ok = 1'b0;
		q = 32'h0;
		// Settled mid-cycle; request held through the accepting edge
		for (i = 0; i < 50; i++) begin
			@(negedge clk_sys_i);
			ok = (avs_waitrequest_o === 1'b0);
			q = avs_readdata_o;
			@(posedge clk_sys_i);
			if (ok) break;
		end
		if (!ok) begin
			mismatches++;
			final_report();
		end
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(q, exp);
	endtask

	// Cycles between two successive counter steps
	task automatic meas(input int exp);
		logic [15:0] c;
		int n;
		c = count_o;
		for (n = 0; n < 600 && count_o === c; n++) @(negedge clk_sys_i);
		if (n == 600) begin
			mismatches++;
			final_report();
		end
		c = count_o;
		for (n = 0; n < 600 && count_o === c; n++) @(negedge clk_sys_i);
		if (n == 600) begin
			mismatches++;
			final_report();
		end
		chk(n, exp);
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		srst_i = 1'b1;
		avs_address_i = 8'h00;
		avs_read_i = 1'b0;
		avs_write_i = 1'b0;
		avs_writedata_i = 32'h0;
		avs_byteenable_i = 4'hF;
		ch_norm_i = 2'h1;
		mismatches = 0;
		num_checks = 0;
		repeat (3) @(posedge clk_sys_i);
		srst_i <= 1'b0;
		@(negedge clk_sys_i);
		chk(count_o, 32'h0);
		rdc(`FTR_OFF_SC, 32'h0);
		rdc(8'h98, 32'h0);
		$display("test reset done");

		wr(8'h98, 32'hFFFFFFFF);
		rdc(8'h98, 32'h2FF);
		rdc(8'hFC, 32'h0);
		wr(8'h98, 32'h0);
		$display("test load register done");

		// Buffers only; permit low must block the copy
		wr(`FTR_OFF_MOD, 32'h3);
		wr(`FTR_OFF_COUNTER_START_VALUE, 32'h1);
		wr(`FTR_OFF_CV0, 32'h2);
		wr(`FTR_OFF_SC, 32'h08);
		repeat (20) @(posedge clk_sys_i);
		rdc(`FTR_OFF_MOD, 32'h0);
		chk(pulses, 32'h0);
		wr(8'h98, 32'h200);
		repeat (20) @(posedge clk_sys_i);
		rdc(`FTR_OFF_MOD, 32'h3);
		rdc(`FTR_OFF_COUNTER_START_VALUE, 32'h1);
		chk(pulses != 0, 32'h1);
		chk(count_o >= 16'h1 && count_o <= 16'h3, 32'h1);
		$display("test period load done");

		wr(`FTR_OFF_SC, 32'h0);
		@(negedge clk_sys_i);
		held = count_o;
		repeat (20) @(posedge clk_sys_i);
		@(negedge clk_sys_i);
		chk(count_o, held);
		rdc(`FTR_OFF_MOD, 32'h3);
		$display("test stop done");

		wr(`FTR_OFF_MOD, 32'hFFFF);
		wr(`FTR_OFF_SC, 32'h08);
		repeat (10) @(posedge clk_sys_i);
		wr(`FTR_OFF_SC, 32'h0);
		rdc(`FTR_OFF_MOD, 32'hFFFF);
		// Channel 0 excluded, then included, as a load trigger
		for (int s = 0; s < 2; s++) begin
			wr(8'h98, 32'h200 | s);
			wr(`FTR_OFF_CNT, 32'h0);
			base = pulses;
			wr(`FTR_OFF_SC, 32'h08);
			repeat (20) @(posedge clk_sys_i);
			wr(`FTR_OFF_SC, 32'h0);
			repeat (2) @(posedge clk_sys_i);
			chk(pulses - base, s);
		end
		$display("test match load done");

		// Prescale ratios, then fixed and external sources
		for (int k = 0; k < 8; k++) begin
			wr(`FTR_OFF_SC, 32'h08 | k);
			meas(1 << k);
		end
		wr(`FTR_OFF_SC, 32'h10);
		meas(4);
		wr(`FTR_OFF_SC, 32'h18);
		meas(10);
		wr(`FTR_OFF_SC, 32'h0);
		$display("test clock sources done");

		wr(`FTR_OFF_SWO, 32'h203);
		repeat (2) @(posedge clk_sys_i);
		chk(ch_out_o, 32'h2);
		wr(`FTR_OFF_SWO, 32'h001);
		repeat (2) @(posedge clk_sys_i);
		chk(ch_out_o, 32'h0);
		wr(`FTR_OFF_SWO, 32'h0);
		repeat (2) @(posedge clk_sys_i);
		chk(ch_out_o, 32'h1);
		$display("test override done");
		final_report();
	end
endmodule
